// ===== design/eeprom_fe_defines.svh
// constants of the serial slave front end: codes, field positions, timing
// assumes inclusion by bare name; definitions only
`ifndef EEPROM_FE_DEFINES_SVH
`define EEPROM_FE_DEFINES_SVH

// ============================================================
// select byte fields
`define TYPE_MAIN        4'hA
`define TYPE_ID          4'hB
`define SEL_TYPE_MSB     7
`define SEL_TYPE_LSB     4
`define SEL_CHIP_HI_BIT  3
`define SEL_CHIP_LO_BIT  2
`define SEL_A8_BIT       1
`define SEL_RW_BIT       0

// ============================================================
// address and data byte fields
`define ADDR_W           9
`define ID_LOCK_BIT      7
`define LOCK_DATA_BIT    1
`define ACK_SLOT         4'h8
`define STOP_SLOT        4'h1
`define BITS_LAST        4'h7

// ============================================================
// reset values
`define RST_BYTE         8'h00
`define RST_ADDR         9'h000

// ============================================================
// write cycle timing
`define TW_MS            4
`define CLK_KHZ          25000
`define TW_CYCLES        (`TW_MS * `CLK_KHZ)

`endif

// ===== design/fe_pkg.sv
// types shared by the serial slave front end
// assumes the defines header is included first by each user
package fe_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_DEVSEL    = 3'b001,
        ST_ADDR      = 3'b010,
        ST_WDATA     = 3'b011,
        ST_RDATA     = 3'b100,
        ST_WAIT_STOP = 3'b101,
        ST_BUSY      = 3'b110
    } fsm_state_t;

    typedef struct packed {
        logic       id_page;
        logic [8:0] addr;
        logic [8:0] waddr;
        logic [7:0] wdata;
        logic       wr_strobe;
        logic       commit;
        logic       lock_req;
    } mem_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic chip_hi;
        logic chip_lo;
        logic wp;
        logic tgl;
        logic bit_val;
    } pin_sync_t;

endpackage

// ===== design/sync_2ff.sv
// two flip-flop level synchroniser
// assumes inputs are levels that hold for several clk periods
`timescale 1ns/100ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] out;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = d;
        st_nxt.out  = st_r.meta;
        if (!reset_n) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign q = st_r.out;
endmodule // sync_2ff

// ===== design/scl_bit_capture.sv
// link-side bit sampler, clocked by the serial clock
// assumes reset_n is held low across at least three serial clock edges
`timescale 1ns/100ps
module scl_bit_capture (
    input  wire logic scl_clk,
    input  wire logic reset_n,
    input  wire logic sda_in,
    output logic      bit_val,
    output logic      bit_tgl
);
    typedef struct packed {
        logic rst_meta;
        logic rst_ok;
        logic bit_val;
        logic tgl;
    } cap_state_t;

    cap_state_t st_r;
    cap_state_t st_nxt;

    // ============================================================
    // sample on each rising serial clock edge, toggle marks the event
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rst_meta = reset_n;
        st_nxt.rst_ok   = st_r.rst_meta;
        if (!st_r.rst_ok) begin
            st_nxt.bit_val = 1'b0;
            st_nxt.tgl     = 1'b0;
        end else begin
            st_nxt.bit_val = sda_in; // R10
            st_nxt.tgl     = ~st_r.tgl;
        end
    end

    always_ff @(posedge scl_clk) begin
        st_r <= st_nxt;
    end

    assign bit_val = st_r.bit_val;
    assign bit_tgl = st_r.tgl;

    AST_BIT_EVENT_TOGGLES: assert property ( // R10
        @(posedge scl_clk) disable iff (!st_r.rst_ok)
        st_r.rst_ok |=> (st_r.tgl != $past(st_r.tgl)) && (st_r.bit_val == $past(sda_in)))
        else $error("bit capture did not toggle on serial clock rise");
endmodule // scl_bit_capture

// ===== design/eeprom_serial_slave_front_end.sv
// two-wire serial slave front end of a 512 byte memory with an id page
// assumes rd_data follows mem_req.addr/id_page combinationally on clk;
// scl_clk and all pins are asynchronous to clk
//
// Contract
// R1 - select bits b3,b2 compared with chip pins
// R2 - floating chip pin reads as zero
// R3 - write protect high blocks array writes
// R4 - protected: ack select/address, nack data
// R5 - start is data falling with clock high
// R6 - watch for start except during write cycle
// R7 - stop is data rising, ends communication
// R8 - stop after write launches write cycle
// R9 - write cycle finishes within four milliseconds
// R10 - sample data on rising serial clock
// R11 - master changes data only while clock low
// R12 - receiver pulls data low on ninth pulse
// R13 - accept only type 1010b or 1011b
// R14 - respond only on matching chip address
// R15 - select byte msb first, last bit direction
// R16 - b1 is top address bit for array
// R17 - mismatch: release bus, standby until start
// R18 - match: ack select, then ack address
// R19 - id page address and lock decode
// R20 - sixteen byte pages, nine address bits
// R21 - during write cycle release data, ignore all
// R22 - only stop in tenth slot writes
// R23 - drive data only open-drain low
`timescale 1ns/100ps
`include "eeprom_fe_defines.svh"
module eeprom_serial_slave_front_end #(
    parameter int unsigned TW_CYCLES = `TW_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            scl_clk,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe_n,
    input  wire logic            chip_addr_pin_high,
    input  wire logic            chip_addr_pin_low,
    input  wire logic            write_protect_input,
    input  wire logic            id_locked,
    input  wire logic [7:0]      rd_data,
    output fe_pkg::mem_req_t     mem_req,
    output logic                 busy
);
    localparam logic [16:0] TW_LAST = 17'(TW_CYCLES - 1);

    typedef struct packed {
        fe_pkg::fsm_state_t state;
        logic [3:0]         cnt;
        logic [7:0]         shift;
        logic [7:0]         tx;
        logic               ack;
        logic               rw;
        logic               lock_mode;
        logic               wr_pend;
        fe_pkg::mem_req_t   req;
        logic               sda_out;
        logic               sda_oe_n;
        logic               busy;
        logic [16:0]        tw_cnt;
        logic               scl_d;
        logic               sda_d;
        logic               tgl_d;
        logic               tgl_dd;
    } fe_state_t;

    fe_state_t         st_r;
    fe_state_t         st_nxt;
    fe_pkg::pin_sync_t pin_raw;
    fe_pkg::pin_sync_t pin_s;
    logic              cap_bit;
    logic              cap_tgl;

    // ============================================================
    // helpers
    function automatic logic sel_match(input logic [7:0] b, input logic hi, input logic lo);
        logic type_ok;
        type_ok = (b[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_MAIN) ||
                  (b[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_ID);
        return type_ok && (b[`SEL_CHIP_HI_BIT] == hi) && (b[`SEL_CHIP_LO_BIT] == lo);
    endfunction

    function automatic logic [8:0] next_addr(input logic [8:0] a, input logic page_roll);
        logic [8:0] inc;
        inc = a + 9'h001;
        return page_roll ? {a[8:4], inc[3:0]} : inc;
    endfunction

    // ============================================================
    // link domain and pin synchronisers
    scl_bit_capture u_cap (
        .scl_clk (scl_clk),
        .reset_n (reset_n),
        .sda_in  (sda_in),
        .bit_val (cap_bit),
        .bit_tgl (cap_tgl)
    );

    // unconnected chip pins are held low by pull-downs outside the core
    assign pin_raw = '{scl: scl_clk, sda: sda_in, chip_hi: chip_addr_pin_high,
                       chip_lo: chip_addr_pin_low, wp: write_protect_input,
                       tgl: cap_tgl, bit_val: cap_bit}; // R2

    sync_2ff #(.WIDTH($bits(fe_pkg::pin_sync_t))) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (pin_raw),
        .q       (pin_s)
    );

    // ============================================================
    // protocol engine
    logic       rise_ev;
    logic       fall_ev;
    logic       start_ev;
    logic       stop_ev;
    logic [7:0] byte_in;
    logic       data_ok;

    assign rise_ev  = st_r.tgl_d ^ st_r.tgl_dd;
    assign fall_ev  = st_r.scl_d & ~pin_s.scl;
    assign start_ev = pin_s.scl & st_r.scl_d & st_r.sda_d & ~pin_s.sda; // R5
    assign stop_ev  = pin_s.scl & st_r.scl_d & ~st_r.sda_d & pin_s.sda; // R7
    assign byte_in  = {st_r.shift[6:0], pin_s.bit_val};
    // array writes blocked by protect; id page also by its lock
    assign data_ok  = ~pin_s.wp & ~(st_r.req.id_page & id_locked); // R3

    always_comb begin
        st_nxt               = st_r;
        st_nxt.req.wr_strobe = 1'b0;
        st_nxt.req.commit    = 1'b0;
        st_nxt.req.lock_req  = 1'b0;
        st_nxt.sda_out       = 1'b0; // R23
        st_nxt.scl_d         = pin_s.scl;
        st_nxt.sda_d         = pin_s.sda;
        st_nxt.tgl_d         = pin_s.tgl;
        st_nxt.tgl_dd        = st_r.tgl_d;
        if (st_r.state == fe_pkg::ST_BUSY) begin
            // bus ignored and released while the write cycle runs
            st_nxt.sda_oe_n = 1'b1; // R21
            if (st_r.tw_cnt == TW_LAST) begin
                st_nxt.state  = fe_pkg::ST_IDLE; // R9
                st_nxt.busy   = 1'b0;
                st_nxt.tw_cnt = 17'h00000;
            end else begin
                st_nxt.tw_cnt = st_r.tw_cnt + 17'h00001;
            end
        end else if (start_ev) begin
            st_nxt.state    = fe_pkg::ST_DEVSEL; // R6
            st_nxt.cnt      = 4'h0;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.wr_pend  = 1'b0;
        end else if (stop_ev) begin
            st_nxt.sda_oe_n = 1'b1; // R7
            if (st_r.state == fe_pkg::ST_WDATA && st_r.cnt == `STOP_SLOT && st_r.wr_pend) begin
                st_nxt.state      = fe_pkg::ST_BUSY; // R22
                st_nxt.busy       = 1'b1;
                st_nxt.req.commit = 1'b1; // R8
                st_nxt.tw_cnt     = 17'h00000;
            end else begin
                st_nxt.state = fe_pkg::ST_IDLE;
            end
        end else begin
            if (rise_ev && st_r.state != fe_pkg::ST_IDLE && st_r.state != fe_pkg::ST_WAIT_STOP) begin
                if (st_r.cnt != `ACK_SLOT) begin
                    st_nxt.shift = byte_in; // R15
                    st_nxt.cnt   = st_r.cnt + 4'h1;
                    st_nxt.tx    = {st_r.tx[6:0], 1'b1};
                    if (st_r.cnt == `BITS_LAST) begin
                        case (st_r.state)
                            fe_pkg::ST_DEVSEL: st_nxt.ack = sel_match(byte_in, pin_s.chip_hi,
                                                                      pin_s.chip_lo); // R13 R14 R1
                            fe_pkg::ST_ADDR:   st_nxt.ack = 1'b1; // R18 R4
                            fe_pkg::ST_WDATA:  st_nxt.ack = data_ok; // R4
                            default:           st_nxt.ack = 1'b0;
                        endcase
                    end
                    // a write is pending only while the last data byte was taken
                    if (st_r.state == fe_pkg::ST_WDATA && st_r.cnt == 4'h0) begin
                        st_nxt.wr_pend = st_r.wr_pend & st_r.ack;
                    end
                end else begin
                    st_nxt.cnt = 4'h0;
                    case (st_r.state)
                        fe_pkg::ST_DEVSEL: begin
                            if (st_r.ack) begin
                                st_nxt.rw          = st_r.shift[`SEL_RW_BIT];
                                st_nxt.req.id_page = (st_r.shift[`SEL_TYPE_MSB:`SEL_TYPE_LSB]
                                                      == `TYPE_ID);
                                if (st_r.shift[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_MAIN) begin
                                    st_nxt.req.addr[8] = st_r.shift[`SEL_A8_BIT]; // R16
                                end
                                st_nxt.state = st_r.shift[`SEL_RW_BIT] ? fe_pkg::ST_RDATA
                                                                       : fe_pkg::ST_ADDR;
                            end else begin
                                st_nxt.state = fe_pkg::ST_WAIT_STOP; // R17
                            end
                        end
                        fe_pkg::ST_ADDR: begin
                            if (st_r.req.id_page) begin
                                st_nxt.lock_mode = st_r.shift[`ID_LOCK_BIT]; // R19
                                st_nxt.req.addr  = {5'h00, st_r.shift[3:0]};
                            end else begin
                                st_nxt.lock_mode     = 1'b0;
                                st_nxt.req.addr[7:0] = st_r.shift; // R20
                            end
                            st_nxt.state = fe_pkg::ST_WDATA;
                        end
                        fe_pkg::ST_WDATA: begin
                            if (st_r.ack) begin
                                st_nxt.wr_pend = 1'b1;
                                if (st_r.lock_mode) begin
                                    st_nxt.req.lock_req = st_r.shift[`LOCK_DATA_BIT]; // R19
                                end else begin
                                    st_nxt.req.wr_strobe = 1'b1;
                                    st_nxt.req.waddr     = st_r.req.addr;
                                    st_nxt.req.wdata     = st_r.shift;
                                    st_nxt.req.addr      = next_addr(st_r.req.addr, 1'b1); // R20
                                end
                            end
                        end
                        fe_pkg::ST_RDATA: begin
                            st_nxt.req.addr = next_addr(st_r.req.addr, st_r.req.id_page);
                            if (pin_s.bit_val) begin
                                st_nxt.state = fe_pkg::ST_WAIT_STOP;
                            end
                        end
                        default: st_nxt.state = fe_pkg::ST_IDLE;
                    endcase
                end
            end
            if (fall_ev) begin
                case (st_r.state)
                    fe_pkg::ST_DEVSEL,
                    fe_pkg::ST_ADDR,
                    fe_pkg::ST_WDATA: begin
                        st_nxt.sda_oe_n = ~((st_r.cnt == `ACK_SLOT) & st_r.ack); // R12 R18
                    end
                    fe_pkg::ST_RDATA: begin
                        if (st_r.cnt == 4'h0) begin
                            st_nxt.tx       = rd_data;
                            st_nxt.sda_oe_n = rd_data[7]; // R23
                        end else if (st_r.cnt == `ACK_SLOT) begin
                            st_nxt.sda_oe_n = 1'b1;
                        end else begin
                            st_nxt.sda_oe_n = st_r.tx[7];
                        end
                    end
                    default: st_nxt.sda_oe_n = 1'b1;
                endcase
            end
        end
        if (!reset_n) begin
            st_nxt          = '0;
            st_nxt.state    = fe_pkg::ST_IDLE;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.scl_d    = 1'b1;
            st_nxt.sda_d    = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign sda_out  = st_r.sda_out;
    assign sda_oe_n = st_r.sda_oe_n;
    assign mem_req  = st_r.req;
    assign busy     = st_r.busy;

    // ============================================================
    // checks
    AST_BUSY_RELEASED: assert property ( // R21
        @(posedge clk) disable iff (!reset_n)
        st_r.busy |-> st_r.sda_oe_n && !st_r.req.wr_strobe)
        else $error("data line driven or write taken during write cycle");

    AST_BUSY_IGNORES_START: assert property ( // R6
        @(posedge clk) disable iff (!reset_n)
        (st_r.state == fe_pkg::ST_BUSY) && start_ev && (st_r.tw_cnt != TW_LAST)
        |=> st_r.state == fe_pkg::ST_BUSY)
        else $error("start accepted during write cycle");

    AST_TW_BOUND: assert property ( // R9
        @(posedge clk) disable iff (!reset_n)
        (st_r.state == fe_pkg::ST_BUSY) && (st_r.tw_cnt == TW_LAST)
        |=> !st_r.busy && st_r.state == fe_pkg::ST_IDLE)
        else $error("write cycle did not end at its limit");

    AST_COMMIT_STARTS_CYCLE: assert property ( // R8
        @(posedge clk) disable iff (!reset_n)
        $rose(st_r.busy) |-> st_r.req.commit && st_r.tw_cnt == 17'h00000 ##1 st_r.busy[*3])
        else $error("write cycle start without commit");

    AST_STOP_SLOT: assert property ( // R22
        @(posedge clk) disable iff (!reset_n)
        stop_ev && !((st_r.state == fe_pkg::ST_WDATA) && (st_r.cnt == `STOP_SLOT))
        && st_r.state != fe_pkg::ST_BUSY |=> !st_r.busy && st_r.state == fe_pkg::ST_IDLE)
        else $error("stop outside the tenth slot launched a write");

    AST_START_SELECTS: assert property ( // R5
        @(posedge clk) disable iff (!reset_n)
        start_ev && st_r.state != fe_pkg::ST_BUSY
        |=> st_r.state == fe_pkg::ST_DEVSEL && st_r.cnt == 4'h0 && st_r.sda_oe_n)
        else $error("start not followed by select phase");

    AST_SELECT_ACK: assert property ( // R13
        @(posedge clk) disable iff (!reset_n)
        rise_ev && st_r.state == fe_pkg::ST_DEVSEL && st_r.cnt == `BITS_LAST
        |=> st_r.ack == sel_match(st_r.shift, pin_s.chip_hi, pin_s.chip_lo))
        else $error("select byte acknowledge wrong");

    AST_WP_DATA_NACK: assert property ( // R4
        @(posedge clk) disable iff (!reset_n)
        rise_ev && st_r.state == fe_pkg::ST_WDATA && st_r.cnt == `BITS_LAST && pin_s.wp
        |=> !st_r.ack)
        else $error("data byte acknowledged under write protect");

    AST_WP_NO_STROBE: assert property ( // R3
        @(posedge clk) disable iff (!reset_n)
        st_r.req.wr_strobe && !st_r.req.id_page |-> !$past(pin_s.wp, 2))
        else $error("array write issued under write protect");

    AST_DRIVE_SLOTS: assert property ( // R23
        @(posedge clk) disable iff (!reset_n)
        !st_r.sda_oe_n |-> (st_r.state == fe_pkg::ST_RDATA)
        || (st_r.cnt == `ACK_SLOT && st_r.ack) || (st_r.cnt == 4'h0))
        else $error("data line driven outside acknowledge or read slots");

    AST_MISMATCH_STANDBY: assert property ( // R17
        @(posedge clk) disable iff (!reset_n)
        rise_ev && st_r.state == fe_pkg::ST_DEVSEL && st_r.cnt == `ACK_SLOT && !st_r.ack
        && !start_ev && !stop_ev |=> st_r.state == fe_pkg::ST_WAIT_STOP && st_r.sda_oe_n)
        else $error("mismatched select did not go to standby");
endmodule // eeprom_serial_slave_front_end

// ===== testbench/i2c_master_model.sv
// two-wire bus master model: serial clock plus open-drain data pull-down
// assumes the bench resolves the data wire and returns it on sda_wire
`timescale 1ns/100ps
module i2c_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_wire
);
    logic tck = 1'b0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ============================================================
    // link tick; clock stands high between frames
    always #15 tck = ~tck;
    task automatic ph();
        repeat (16) @(posedge tck);
    endtask
    task automatic rst_clocks();
        repeat (3) begin
            @(posedge tck) scl = 1'b0;
            @(posedge tck) scl = 1'b1;
        end
    endtask
    task automatic start();
        sda_low = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_low = 1'b1;
        ph();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_low = 1'b0;
        ph();
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low = ~b;
        ph();
        scl = 1'b1;
        ph();
        r = sda_wire;
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(~more, r);
    endtask
endmodule // i2c_master_model

// ===== testbench/testbench.sv
// self-checking bench of the serial slave front end
// assumes the master model file; memory bytes derive from the address
`timescale 1ns/100ps
module testbench;
    localparam int unsigned TW = 400;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             scl, m_low, sda_out, sda_oe_n, busy, ack;
    logic             chip_hi = 1'b1, chip_lo = 1'b0, wp = 1'b0, id_lock = 1'b0;
    logic [7:0]       rd_data, d;
    logic [16:0]      last_wr = 17'h0;
    fe_pkg::mem_req_t mem_req;
    int               bad_count = 0, n_tests = 0, n_commit = 0, n_lock = 0, busy_len = 0;
    wire logic        sda = !(m_low || (!sda_oe_n && !sda_out));
    logic [7:0]       bad_sel [5] = '{8'hA2, 8'hAE, 8'h9A, 8'hCA, 8'hBE};

    assign rd_data = mem_req.id_page ? {4'hC, mem_req.addr[3:0]}
                                     : mem_req.addr[7:0] ^ {8{mem_req.addr[8]}};
    initial forever #20 clk = ~clk;

    eeprom_serial_slave_front_end #(.TW_CYCLES(TW)) i_eeprom_serial_slave_front_end (
        .clk(clk), .reset_n(reset_n), .scl_clk(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_addr_pin_high(chip_hi),
        .chip_addr_pin_low(chip_lo), .write_protect_input(wp), .id_locked(id_lock),
        .rd_data(rd_data), .mem_req(mem_req), .busy(busy));
    i2c_master_model i_i2c_master_model (.scl(scl), .sda_low(m_low), .sda_wire(sda));

    // ============================================================
    // monitor of the memory side
    always @(posedge clk) begin
        if (mem_req.wr_strobe === 1'b1) last_wr = {mem_req.waddr, mem_req.wdata};
        if (mem_req.commit === 1'b1) n_commit++;
        if (mem_req.lock_req === 1'b1) n_lock++;
        if (busy === 1'b1) busy_len++;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic xfer(input logic [7:0] b, input logic exp_ack);
        i_i2c_master_model.send(b, ack);
        chk(17'(ack), 17'(exp_ack));
    endtask
    task automatic settle();
        for (int k = 0; busy !== 1'b0; k++) begin
            if (k > TW + 300) begin
                bad_count++;
                give_verdict();
            end
            @(negedge clk);
        end
    endtask

    // ============================================================
    // main sequence
    initial begin
        fork
            i_i2c_master_model.rst_clocks();
            repeat (5) @(negedge clk);
        join
        @(negedge clk);
        reset_n = 1'b1;
        // bit sampler leaves its own reset only on later serial clock rises
        i_i2c_master_model.rst_clocks();
        repeat (8) @(negedge clk);
        i_i2c_master_model.start();
        xfer(8'hAA, 1'b1);
        xfer(8'h0F, 1'b1);
        xfer(8'h11, 1'b1);
        chk(last_wr, {9'h10F, 8'h11});
        xfer(8'h22, 1'b1);
        chk(last_wr, {9'h100, 8'h22});
        i_i2c_master_model.stop();
        chk(17'(n_commit), 17'h1);
        i_i2c_master_model.start();
        xfer(8'hAA, 1'b0);
        i_i2c_master_model.stop();
        settle();
        chk(17'(busy_len), 17'(TW));
        foreach (bad_sel[i]) begin
            i_i2c_master_model.start();
            xfer(bad_sel[i], 1'b0);
            xfer(8'h00, 1'b0);
            i_i2c_master_model.stop();
        end
        @(negedge clk) wp = 1'b1;
        i_i2c_master_model.start();
        xfer(8'hA8, 1'b1);
        xfer(8'h20, 1'b1);
        xfer(8'h5A, 1'b0);
        i_i2c_master_model.stop();
        chk(17'(n_commit), 17'h1);
        @(negedge clk) wp = 1'b0;
        i_i2c_master_model.start();
        xfer(8'hA8, 1'b1);
        xfer(8'h30, 1'b1);
        i_i2c_master_model.stop();
        chk(17'(n_commit), 17'h1);
        i_i2c_master_model.start();
        xfer(8'hAA, 1'b1);
        xfer(8'h05, 1'b1);
        i_i2c_master_model.start();
        xfer(8'hAB, 1'b1);
        i_i2c_master_model.recv(1'b1, d);
        chk(17'(d), 17'hFA);
        i_i2c_master_model.recv(1'b0, d);
        chk(17'(d), 17'hF9);
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        xfer(8'hBA, 1'b1);
        xfer(8'h03, 1'b1);
        xfer(8'h77, 1'b1);
        chk(last_wr, {9'h003, 8'h77});
        i_i2c_master_model.stop();
        settle();
        @(negedge clk) id_lock = 1'b1;
        i_i2c_master_model.start();
        xfer(8'hBA, 1'b1);
        xfer(8'h03, 1'b1);
        xfer(8'h77, 1'b0);
        i_i2c_master_model.stop();
        @(negedge clk) id_lock = 1'b0;
        i_i2c_master_model.start();
        xfer(8'hBA, 1'b1);
        xfer(8'h80, 1'b1);
        xfer(8'h02, 1'b1);
        i_i2c_master_model.stop();
        chk(17'(n_lock), 17'h1);
        chk(17'(n_commit), 17'h3);
        settle();
        chk(17'(sda_out), 17'h0);
        give_verdict();
    end
endmodule // testbench
